//--- verilog/pcm_audio_frame_mode_control.v
// How it works
// - clearing receive enable stops capture at the next frame end; queued words stay readable
// - receive begins at the next frame start; first channel is first word queued
// - interface enable low holds the serial logic idle; writable while running
// - one data port: writes queue for transmit, reads pop the receive queue
// - bit clock disable stops the bit clock glitch free; zero restarts it
// - decimation select zero gives ratio 16, one gives ratio 32
// - density input enable routes the data pin through the cic filter
// - receive packed merges two channels, first in low half, truncated to 16
// - transmit packed splits a word, low half first channel, high half second
// - bit clock slave select zero drives the clock pin, one takes it in
// - invert zero: drive on rising, sample on falling; one swaps the edges
// - sync slave select zero drives frame sync, one locks onto incoming sync
// - master sync rests low pulsing high, or inverted rests high pulsing low
// - slave frame starts where sync turns active after inactive
// - master frame lasts period field plus one bit clocks
// - sync pulse lasts sync length clocks; zero none, at least period always on
// - transmit begins at next frame start; counter runs when either enable set
`timescale 1ns/10ps
`include "pcm_frame_consts.vh"
module pcm_audio_frame_mode_control #(
    parameter BCLK_HALF = `BCLK_HALF_DEFAULT,
    parameter CHAN_BITS = 16,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    // clock and reset
    input  wire        clock_in,
    input  wire        rst_n_in,
    // apb slave
    input  wire [7:0]  paddr_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // serial link
    input  wire        bit_clock_in,
    output reg         bit_clock_out,
    output reg         bit_clock_oe_out,
    input  wire        frame_sync_line_in,
    output reg         frame_sync_line_out,
    output reg         frame_sync_line_oe_out,
    input  wire        serial_data_in,
    output reg         serial_data_out
);
    localparam [9:0] CH1_LAST  = CHAN_BITS - 1;
    localparam [9:0] CH2_FIRST = CHAN_BITS;
    localparam [9:0] CH2_LAST  = 2 * CHAN_BITS - 1;
    localparam [7:0] DIV_LAST  = BCLK_HALF - 1;

    // software state
    reg                  iface_enable_r;
    reg                  receive_enable_r;
    reg                  transmit_enable_r;
    reg  [31:0]          mode_r;
    // pin synchronisers
    reg                  bck_s1_r;
    reg                  bck_s2_r;
    reg                  fs_s1_r;
    reg                  fs_s2_r;
    reg                  sd_s1_r;
    reg                  sd_s2_r;
    // bit clock and frame
    reg  [7:0]           div_cnt_r;
    reg                  clk_prev_r;
    reg  [9:0]           frame_cnt_r;
    reg                  fs_prev_r;
    reg                  tx_active_r;
    reg                  rx_active_r;
    reg  [CHAN_BITS-1:0] tx_sh_r;
    reg  [15:0]          tx_hi_r;
    reg  [CHAN_BITS-1:0] rx_sh_r;
    reg  [15:0]          rx_lo_r;
    reg                  rx_push_r;
    reg  [31:0]          rx_word_r;
    reg  [31:0]          cs_read;

    wire bclk_disable  = mode_r[`MODE_BCLK_DISABLE];
    wire decim_select  = mode_r[`MODE_DECIM_SELECT];
    wire density_en    = mode_r[`MODE_DENSITY_EN];
    wire rx_packed     = mode_r[`MODE_RX_PACKED];
    wire tx_packed     = mode_r[`MODE_TX_PACKED];
    wire bclk_slave    = mode_r[`MODE_BCLK_SLAVE];
    wire bclk_invert   = mode_r[`MODE_BCLK_INVERT];
    wire sync_slave    = mode_r[`MODE_SYNC_SLAVE];
    wire sync_invert   = mode_r[`MODE_SYNC_INVERT];
    wire [9:0] period  = mode_r[`MODE_PERIOD_MSB:`MODE_PERIOD_LSB];
    wire [9:0] sync_ln = mode_r[`MODE_SYNCLEN_MSB:`MODE_SYNCLEN_LSB];

    // fifo handshakes
    wire        tx_in_ready;
    wire        tx_out_valid;
    wire [31:0] tx_head;
    wire        rx_in_ready;
    wire        rx_out_valid;
    wire [31:0] rx_head;

    // apb decode
    wire apb_access = psel_in & penable_in;
    wire hit_cs     = (paddr_in == `OFS_CONTROL_STATUS);
    wire hit_data   = (paddr_in == `OFS_DATA_PORT);
    wire hit_mode   = (paddr_in == `OFS_OPERATING_MODE);
    wire mapped     = hit_cs | hit_data | hit_mode;
    wire tx_stall   = pwrite_in & hit_data & ~tx_in_ready;
    wire apb_first  = apb_access & ~pready_out & ~tx_stall;
    wire apb_done   = apb_access & pready_out;
    wire wr_done    = apb_done & pwrite_in;
    wire rx_pop     = apb_first & ~pwrite_in & hit_data & rx_out_valid;
    wire tx_push    = wr_done & hit_data;

    always @*
    begin
        cs_read = 32'h0000_0000;
        cs_read[`CS_IFACE_ENABLE_BIT] = iface_enable_r;
        cs_read[`CS_RECEIVE_ENABLE]   = receive_enable_r;
        cs_read[`CS_TRANSMIT_ENABLE]  = transmit_enable_r;
        cs_read[`CS_TX_SPACE_BIT]     = tx_in_ready;
        cs_read[`CS_RX_DATA_BIT]      = rx_out_valid;
        cs_read[`CS_TX_EMPTY_BIT]     = ~tx_out_valid;
        cs_read[`CS_RX_FULL_BIT]      = ~rx_in_ready;
    end

    // register file; a data write waits while the transmit queue is full
    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pready_out        <= 1'b0;
            pslverr_out       <= 1'b0;
            prdata_out        <= 32'h0000_0000;
            {transmit_enable_r, receive_enable_r, iface_enable_r} <= `CS_RESET;
            mode_r            <= `MODE_RESET;
        end
        else
        begin
            pready_out  <= apb_first;
            pslverr_out <= apb_first & ~mapped;
            if (apb_first && !pwrite_in)
            begin
                if (hit_cs)
                    prdata_out <= cs_read;
                else if (hit_data)
                    prdata_out <= rx_out_valid ? rx_head : 32'h0000_0000;
                else if (hit_mode)
                    prdata_out <= mode_r;
                else
                    prdata_out <= 32'h0000_0000;
            end
            if (wr_done && hit_cs)
            begin
                iface_enable_r    <= pwdata_in[`CS_IFACE_ENABLE_BIT];
                receive_enable_r  <= pwdata_in[`CS_RECEIVE_ENABLE];
                transmit_enable_r <= pwdata_in[`CS_TRANSMIT_ENABLE];
            end
            if (wr_done && hit_mode)
                mode_r <= pwdata_in & `MODE_WRITE_MASK;
        end
    end

    // two flip-flops on every pin input
    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            bck_s1_r <= 1'b0;
            bck_s2_r <= 1'b0;
            fs_s1_r  <= 1'b0;
            fs_s2_r  <= 1'b0;
            sd_s1_r  <= 1'b0;
            sd_s2_r  <= 1'b0;
        end
        else
        begin
            bck_s1_r <= bit_clock_in;
            bck_s2_r <= bck_s1_r;
            fs_s1_r  <= frame_sync_line_in;
            fs_s2_r  <= fs_s1_r;
            sd_s1_r  <= serial_data_in;
            sd_s2_r  <= sd_s1_r;
        end
    end

    // master bit clock: a high phase always completes, so stopping is glitch free
    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            div_cnt_r        <= 8'h00;
            bit_clock_out    <= 1'b0;
            bit_clock_oe_out <= 1'b0;
        end
        else
        begin
            bit_clock_oe_out <= ~bclk_slave;
            if (div_cnt_r >= DIV_LAST)
            begin
                div_cnt_r <= 8'h00;
                if (bit_clock_out || (iface_enable_r && !bclk_disable && !bclk_slave))
                    bit_clock_out <= ~bit_clock_out;
            end
            else
                div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    // logical clock and its edges
    wire clk_level   = (bclk_slave ? bck_s2_r : bit_clock_out) ^ bclk_invert;
    wire clk_run     = iface_enable_r & ~bclk_disable;
    wire drive_edge  = clk_run & clk_level & ~clk_prev_r;
    wire sample_edge = clk_run & ~clk_level & clk_prev_r;

    // frame timing
    wire       fs_level   = fs_s2_r ^ sync_invert;
    wire       live       = transmit_enable_r | receive_enable_r | tx_active_r | rx_active_r;
    wire       slave_strt = fs_level & ~fs_prev_r;
    wire       mast_wrap  = (frame_cnt_r >= period);
    wire [9:0] cnt_nxt    = sync_slave ? (slave_strt ? 10'h000 : frame_cnt_r + 10'h001)
                                       : (mast_wrap ? 10'h000 : frame_cnt_r + 10'h001);
    wire       frame_strt = drive_edge & (sync_slave ? slave_strt : (live & mast_wrap));
    wire       sync_on    = (sync_ln != 10'h000) & ((sync_ln >= period) | (cnt_nxt < sync_ln));
    wire       in_frame   = drive_edge & (sync_slave | live);

    // transmit word selection
    wire       tx_act_now = frame_strt ? transmit_enable_r : tx_active_r;
    wire       second     = (cnt_nxt == CH2_FIRST);
    wire       ch_start   = in_frame & ((cnt_nxt == 10'h000) | second);
    wire [31:0] tx_pick   = tx_packed ? (second ? {16'h0000, tx_hi_r}
                                                : {16'h0000, tx_head[15:0]})
                                      : (tx_out_valid ? tx_head : 32'h0000_0000);
    wire [CHAN_BITS-1:0] tx_word = tx_pick[CHAN_BITS-1:0];
    wire       tx_pop     = ch_start & tx_act_now & tx_out_valid & (~tx_packed | ~second);

    // receive channel ends
    wire [CHAN_BITS-1:0] rx_w = {rx_sh_r[CHAN_BITS-2:0], sd_s2_r};
    wire       rx_end1    = (frame_cnt_r == CH1_LAST);
    wire       rx_end2    = (frame_cnt_r == CH2_LAST);
    wire       pcm_rx     = sample_edge & rx_active_r & ~density_en;
    wire       cic_valid;
    wire [15:0] cic_data;

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            clk_prev_r             <= 1'b0;
            frame_cnt_r            <= 10'h000;
            fs_prev_r              <= 1'b0;
            tx_active_r            <= 1'b0;
            rx_active_r            <= 1'b0;
            tx_sh_r                <= {CHAN_BITS{1'b0}};
            tx_hi_r                <= 16'h0000;
            rx_sh_r                <= {CHAN_BITS{1'b0}};
            rx_lo_r                <= 16'h0000;
            rx_push_r              <= 1'b0;
            rx_word_r              <= 32'h0000_0000;
            serial_data_out        <= 1'b0;
            frame_sync_line_out    <= 1'b0;
            frame_sync_line_oe_out <= 1'b0;
        end
        else if (!iface_enable_r)
        begin
            clk_prev_r             <= clk_level;
            frame_cnt_r            <= period;
            tx_active_r            <= 1'b0;
            rx_active_r            <= 1'b0;
            rx_push_r              <= 1'b0;
            serial_data_out        <= 1'b0;
            frame_sync_line_out    <= sync_invert;
            frame_sync_line_oe_out <= ~sync_slave;
        end
        else
        begin
            clk_prev_r             <= clk_level;
            frame_sync_line_oe_out <= ~sync_slave;
            rx_push_r              <= 1'b0;
            if (drive_edge)
            begin
                fs_prev_r <= fs_level;
                if (sync_slave || live)
                    frame_cnt_r <= cnt_nxt;
                else
                    frame_cnt_r <= period;
                frame_sync_line_out <= (live & sync_on) ^ sync_invert;
            end
            if (frame_strt)
            begin
                tx_active_r <= transmit_enable_r;
                rx_active_r <= receive_enable_r;
            end
            // transmit shifter, msb first
            if (ch_start)
            begin
                serial_data_out <= tx_act_now & tx_word[CHAN_BITS-1];
                tx_sh_r         <= tx_word << 1;
                if (tx_pop && tx_packed)
                    tx_hi_r <= tx_head[31:16];
                else if (tx_packed && !second)
                    tx_hi_r <= 16'h0000;
            end
            else if (in_frame)
            begin
                serial_data_out <= (cnt_nxt <= CH2_LAST) & tx_active_r & tx_sh_r[CHAN_BITS-1];
                tx_sh_r         <= tx_sh_r << 1;
            end
            // receive shifter
            if (pcm_rx)
            begin
                rx_sh_r <= rx_w;
                if (rx_end1 && rx_packed)
                    rx_lo_r <= rx_w[15:0];
                else if (rx_end1 || rx_end2)
                begin
                    rx_push_r <= rx_in_ready;
                    rx_word_r <= rx_packed ? {rx_w[15:0], rx_lo_r}
                                           : {{(32-CHAN_BITS){1'b0}}, rx_w};
                end
            end
            else if (cic_valid && rx_active_r && density_en)
            begin
                rx_push_r <= rx_in_ready;
                rx_word_r <= {16'h0000, cic_data};
            end
        end
    end

    cic_decimator #(
        .ACC_W (12)
    ) u_cic (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .strobe_in     (sample_edge & density_en),
        .bit_in        (sd_s2_r),
        .ratio_sel_in  (decim_select),
        .out_valid_out (cic_valid),
        .out_data_out  (cic_data)
    );

    sync_fifo #(
        .WIDTH  (32),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) u_tx_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (tx_push),
        .in_ready_out  (tx_in_ready),
        .in_data_in    (pwdata_in),
        .out_valid_out (tx_out_valid),
        .out_ready_in  (tx_pop),
        .out_data_out  (tx_head)
    );

    sync_fifo #(
        .WIDTH  (32),
        .DEPTH  (FIFO_DEPTH),
        .ADDR_W (FIFO_AW)
    ) u_rx_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (rx_push_r),
        .in_ready_out  (rx_in_ready),
        .in_data_in    (rx_word_r),
        .out_valid_out (rx_out_valid),
        .out_ready_in  (rx_pop),
        .out_data_out  (rx_head)
    );
endmodule

//--- verilog/pcm_frame_consts.vh
`ifndef PCM_FRAME_CONSTS_VH
`define PCM_FRAME_CONSTS_VH

// register byte offsets on the apb bus
`define OFS_CONTROL_STATUS  8'h00
`define OFS_DATA_PORT       8'h04
`define OFS_OPERATING_MODE  8'h08

// control_status fields
`define CS_IFACE_ENABLE_BIT 0
`define CS_RECEIVE_ENABLE   1
`define CS_TRANSMIT_ENABLE  2
`define CS_TX_SPACE_BIT     19
`define CS_RX_DATA_BIT      20
`define CS_TX_EMPTY_BIT     21
`define CS_RX_FULL_BIT      22

// operating_mode fields
`define MODE_BCLK_DISABLE   28
`define MODE_DECIM_SELECT   27
`define MODE_DENSITY_EN     26
`define MODE_RX_PACKED      25
`define MODE_TX_PACKED      24
`define MODE_BCLK_SLAVE     23
`define MODE_BCLK_INVERT    22
`define MODE_SYNC_SLAVE     21
`define MODE_SYNC_INVERT    20
`define MODE_PERIOD_MSB     19
`define MODE_PERIOD_LSB     10
`define MODE_SYNCLEN_MSB    9
`define MODE_SYNCLEN_LSB    0
`define MODE_WRITE_MASK     32'h1fff_ffff

// reset values
`define CS_RESET            3'h0
`define MODE_RESET          32'h0000_0000

// timing counts
`define BCLK_HALF_DEFAULT   4
`define DECIM_LAST_16       5'h0f
`define DECIM_LAST_32       5'h1f

`endif

//--- verilog/sync_fifo.v
`timescale 1ns/10ps
module sync_fifo #(
    parameter WIDTH  = 32,
    parameter DEPTH  = 32,
    parameter ADDR_W = 5
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             rst_n_in,
    // filling side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // draining side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    localparam [ADDR_W:0] FULL_COUNT = DEPTH;

    reg [WIDTH-1:0]  mem_r [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr_r;
    reg [ADDR_W-1:0] rd_ptr_r;
    reg [ADDR_W:0]   count_r;

    wire do_push = in_valid_in & in_ready_out;
    wire do_pop  = out_valid_out & out_ready_in;

    assign in_ready_out  = (count_r != FULL_COUNT);
    assign out_valid_out = (count_r != {(ADDR_W+1){1'b0}});
    assign out_data_out  = mem_r[rd_ptr_r];

    always @(posedge clock_in)
    begin
        if (do_push)
            mem_r[wr_ptr_r] <= in_data_in;
    end

    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_r <= {ADDR_W{1'b0}};
            rd_ptr_r <= {ADDR_W{1'b0}};
            count_r  <= {(ADDR_W+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (do_push && !do_pop)
                count_r <= count_r + 1'b1;
            else if (do_pop && !do_push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule

//--- verilog/cic_decimator.v
`timescale 1ns/10ps
`include "pcm_frame_consts.vh"
module cic_decimator #(
    parameter ACC_W = 12
) (
    // clock and reset
    input  wire        clock_in,
    input  wire        rst_n_in,
    // density-modulated bit stream
    input  wire        strobe_in,
    input  wire        bit_in,
    input  wire        ratio_sel_in,
    // decimated samples
    output reg         out_valid_out,
    output reg  [15:0] out_data_out
);
    reg  [ACC_W-1:0] integ1_r;
    reg  [ACC_W-1:0] integ2_r;
    reg  [ACC_W-1:0] delay1_r;
    reg  [ACC_W-1:0] delay2_r;
    reg  [4:0]       dec_cnt_r;

    wire [4:0]       dec_last = ratio_sel_in ? `DECIM_LAST_32 : `DECIM_LAST_16;
    wire [ACC_W-1:0] comb1    = integ2_r - delay1_r;
    wire [ACC_W-1:0] comb2    = comb1 - delay2_r;

    // second order filter, gain ratio squared, scaled so full scale is 16'h8000
    always @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            integ1_r      <= {ACC_W{1'b0}};
            integ2_r      <= {ACC_W{1'b0}};
            delay1_r      <= {ACC_W{1'b0}};
            delay2_r      <= {ACC_W{1'b0}};
            dec_cnt_r     <= 5'h00;
            out_valid_out <= 1'b0;
            out_data_out  <= 16'h0000;
        end
        else
        begin
            out_valid_out <= 1'b0;
            if (strobe_in)
            begin
                integ1_r <= integ1_r + {{(ACC_W-1){1'b0}}, bit_in};
                integ2_r <= integ2_r + integ1_r;
                if (dec_cnt_r >= dec_last)
                begin
                    dec_cnt_r     <= 5'h00;
                    delay1_r      <= integ2_r;
                    delay2_r      <= comb1;
                    out_valid_out <= 1'b1;
                    out_data_out  <= ratio_sel_in ? {comb2[10:0], 5'h00}
                                                  : {comb2[8:0], 7'h00};
                end
                else
                    dec_cnt_r <= dec_cnt_r + 5'h01;
            end
        end
    end
endmodule

//--- verif/pcm_frame_monitor.sv
`timescale 1ns/10ps
module pcm_frame_monitor #(
    parameter BCLK_HALF = 4
) (
    input wire        clock_in,
    input wire        rst_n_in,
    input wire [7:0]  paddr_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        bit_clock_in,
    input wire        bit_clock_out,
    input wire        bit_clock_oe_out,
    input wire        frame_sync_line_in,
    input wire        frame_sync_line_out,
    input wire        frame_sync_line_oe_out,
    input wire        serial_data_in,
    input wire        serial_data_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready held");
    a_ready_after_access: assert property ($rose(penable_in) && psel_in && paddr_in != 8'h04
        |=> pready_out) else $error("no ready");
    a_error_on_unmapped: assert property (pready_out
        |-> pslverr_out == (paddr_in > 8'h08 || paddr_in[1:0] != 2'h0)) else $error("bad slverr");
    a_error_reads_zero: assert property (pslverr_out && !pwrite_in
        |-> pready_out && prdata_out == 32'h0) else $error("error read data");
    a_bclk_high_hold: assert property (bit_clock_oe_out && $rose(bit_clock_out)
        |-> bit_clock_out[*4]) else $error("short high");
    a_bclk_low_hold: assert property (bit_clock_oe_out && $fell(bit_clock_out)
        |-> !bit_clock_out[*4]) else $error("short low");
    a_data_on_drive: assert property (bit_clock_oe_out && $changed(serial_data_out)
        |-> bit_clock_out || !$past(bit_clock_out, 4)) else $error("data off edge");
    a_sync_on_drive: assert property (bit_clock_oe_out && $changed(frame_sync_line_out)
        |-> bit_clock_out || !$past(bit_clock_out, 4)) else $error("sync off edge");
endmodule
bind pcm_audio_frame_mode_control pcm_frame_monitor #(.BCLK_HALF(BCLK_HALF)) mon_u (.*);

//--- verif/codec_model.sv
`timescale 1ns/10ps
module codec_model (
    // control
    input  wire        run_in,
    input  wire [31:0] pattern_in,
    // link
    input  wire        data_in,
    output reg         bclk_out,
    output reg         sync_out,
    output wire        data_out
);
    reg  [4:0] n;
    reg        bit_r;
    wire #2    echo = data_in;
    assign data_out = run_in ? bit_r : echo;
    initial
    begin
        bclk_out = 1'h0;
        sync_out = 1'h0;
        n = 5'h1f;
        bit_r = 1'h0;
    end
    // clock stands still while run_in is low
    always #16 if (run_in) bclk_out = ~bclk_out;
    always @(posedge bclk_out)
    begin
        n <= n + 5'h01;
        bit_r <= pattern_in[~(n + 5'h01)];
    end
    always @(negedge bclk_out) sync_out <= (n == 5'h1f);
endmodule

//--- verif/pcm_audio_frame_mode_control_test.sv
`timescale 1ns/10ps
module pcm_audio_frame_mode_control_test;
    reg         clock_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, run = 0;
    reg  [7:0]  paddr_in = 8'h0;
    reg  [31:0] pwdata_in = 0, rd, seed = 89, w0, w1, pat;
    reg         b;
    wire [31:0] prdata_out;
    wire        pready_out, pslverr_out, bco, bcoe, fso, fsoe, sdo, cclk, csync, cdata;
    integer     num_errors = 0, n_checks = 0, i, t0;
    always #2 clock_in = ~clock_in;
`define CHK(a, e) begin n_checks = n_checks + 1; if ((a) !== (e)) begin \
 num_errors = num_errors + 1; $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
    pcm_audio_frame_mode_control dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .bit_clock_in(bcoe ? bco : cclk), .bit_clock_out(bco), .bit_clock_oe_out(bcoe),
        .frame_sync_line_in(fsoe ? fso : csync), .frame_sync_line_out(fso),
        .frame_sync_line_oe_out(fsoe), .serial_data_in(cdata), .serial_data_out(sdo));
    codec_model codec_u (.run_in(run), .pattern_in(pat), .data_in(sdo), .bclk_out(cclk),
        .sync_out(csync), .data_out(cdata));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock_in);
            psel_in <= 1; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
            @(posedge clock_in);
            penable_in <= 1;
            @(posedge clock_in);
            while (pready_out !== 1'h1) @(posedge clock_in);
            rd = prdata_out;
            psel_in <= 0; penable_in <= 0;
        end
    endtask
    task drain(input [31:0] e);
        begin
            apb(0, 8'h00, 0);
            while (rd[20] === 1'h1)
            begin
                apb(0, 8'h04, 0);
                `CHK(rd, e)
                apb(0, 8'h00, 0);
            end
        end
    endtask
    task loop(input [31:0] m);
        begin
            seed = xs(seed); w0 = seed; seed = xs(seed); w1 = seed;
            apb(1, 8'h08, m); apb(1, 8'h04, w0); apb(1, 8'h04, w1); apb(1, 8'h00, 7);
            @(posedge fso); t0 = $time;
            if (m[9:0] == 10'h3)
            begin
                @(negedge fso);
                `CHK(($time - t0) / 4, 24)
                @(posedge fso);
                `CHK(($time - t0) / 4, 256)
            end
            else
            begin
                repeat (400) @(posedge clock_in);
                `CHK(fso, 1'h1)
            end
            repeat (600) @(posedge clock_in);
            apb(1, 8'h00, 1);
            repeat (600) @(posedge clock_in);
            apb(0, 8'h04, 0);
            `CHK(rd, m[24] ? w0 : {16'h0, w0[15:0]})
            apb(0, 8'h04, 0);
            `CHK(rd, m[24] ? w1 : {16'h0, w1[15:0]})
            drain(0);
            apb(1, 8'h00, 0);
            $display("done: loopback %h", m);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        conclude;
    end
    initial
    begin
        pat = 0;
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1;
        apb(0, 8'h00, 0);
        `CHK(rd, 32'h0028_0000)
        apb(0, 8'h0c, 0);
        `CHK(rd, 32'h0)
        `CHK(bcoe, 1'h1)
        `CHK(fsoe, 1'h1)
        for (i = 0; i < 4; i = i + 1)
        begin
            seed = xs(seed);
            apb(1, 8'h08, seed); apb(0, 8'h08, 0);
            `CHK(rd, seed & 32'h1fff_ffff)
        end
        apb(1, 8'h08, 32'h00a0_0000); apb(0, 8'h08, 0);
        `CHK(bcoe, 1'h0)
        `CHK(fsoe, 1'h0)
        apb(1, 8'h08, 32'h0010_0000); apb(1, 8'h00, 1);
        repeat (4) @(posedge clock_in);
        `CHK(fso, 1'h1)
        apb(1, 8'h00, 0);
        repeat (8) @(posedge clock_in);
        apb(1, 8'h08, 32'h1000_0000); apb(1, 8'h00, 1); b = bco;
        repeat (40) begin @(posedge clock_in); `CHK(bco, b) end
        apb(1, 8'h00, 0);
        $display("done: registers");
        loop(32'h0000_7c03);
        loop(32'h0300_7c28);
        seed = xs(seed); pat = seed; run = 1;
        apb(1, 8'h08, 32'h02a0_0000); apb(1, 8'h00, 3);
        repeat (900) @(posedge clock_in);
        apb(1, 8'h00, 1);
        repeat (600) @(posedge clock_in);
        run = 0;
        apb(0, 8'h00, 0);
        `CHK(rd[20], 1'h1)
        drain({pat[15:0], pat[31:16]});
        $display("done: slave receive");
        conclude;
    end
endmodule
